// file: design/crpt_regs.sv
// reference, bias and power-tune register bank behind the control port
`timescale 1ns/10ps
`default_nettype none
`include "crpt_consts.svh"
module crpt_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control-port register access, same clock domain
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // reference and bias controls
  output logic bias_regulator_gain,
  output crpt_pkg::crpt_bias_t bias_output_select,
  output logic [1:0] reference_fullscale_select,
  // recording path controls
  output logic rec_modclk_half,
  output logic rec_comb_order,
  output logic rec_fir_skip,
  output logic rec_shuffle_rate_double,
  output logic rec_lowpower_filter,
  // playback path controls
  output logic play_modclk_half,
  output logic play_shuffle_rate_double,
  output logic play_lowpower_filter,
  output logic play_current_ref_scale,
  // setting flags for software diagnostics
  output logic bias_code_reserved,
  output logic fullscale_code_reserved
);
  crpt_pkg::crpt_byte_t ref_q, rec_q, play_q, rdata_d;
  logic sel_ref, sel_rec, sel_play, sel_none;

  // address decode
  assign sel_ref = (reg_addr == `CRPT_ADDR_REF);
  assign sel_rec = (reg_addr == `CRPT_ADDR_REC);
  assign sel_play = (reg_addr == `CRPT_ADDR_PLAY);
  assign sel_none = !(sel_ref || sel_rec || sel_play); // nothing mapped here

  // the three registers
  crpt_reg8 #(.WMASK(`CRPT_MASK_REF)) u_ref (
    .sys_clk(sys_clk), .rst_n(rst_n), .wr_en(reg_wr & sel_ref),
    .wr_data(reg_wdata), .value_q(ref_q)
  );
  crpt_reg8 #(.WMASK(`CRPT_MASK_REC)) u_rec (
    .sys_clk(sys_clk), .rst_n(rst_n), .wr_en(reg_wr & sel_rec),
    .wr_data(reg_wdata), .value_q(rec_q)
  );
  crpt_reg8 #(.WMASK(`CRPT_MASK_PLAY)) u_play (
    .sys_clk(sys_clk), .rst_n(rst_n), .wr_en(reg_wr & sel_play),
    .wr_data(reg_wdata), .value_q(play_q)
  );

  // read mux; unmapped addresses read zero
  assign rdata_d = sel_ref ? ref_q : sel_rec ? rec_q : sel_play ? play_q : 8'h00;

  // read data registered, updated only on a read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  // field outputs re-registered so top outputs come from flops; one cycle behind the store
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bias_regulator_gain <= 1'b0;
      bias_output_select <= crpt_pkg::CRPT_BIAS_VREF;
      reference_fullscale_select <= 2'h0;
      rec_modclk_half <= 1'b0;
      rec_comb_order <= 1'b0;
      rec_fir_skip <= 1'b0;
      rec_shuffle_rate_double <= 1'b0;
      rec_lowpower_filter <= 1'b0;
      play_modclk_half <= 1'b0;
      play_shuffle_rate_double <= 1'b0;
      play_lowpower_filter <= 1'b0;
      play_current_ref_scale <= 1'b0;
      bias_code_reserved <= 1'b0;
      fullscale_code_reserved <= 1'b0;
    end else begin
      bias_regulator_gain <= ref_q[`CRPT_BIT_GAIN];
      bias_output_select <= crpt_pkg::crpt_bias_t'(ref_q[`CRPT_LSB_BIAS +: 2]);
      reference_fullscale_select <= ref_q[`CRPT_LSB_FS +: 2];
      rec_modclk_half <= rec_q[`CRPT_BIT_MODCLK];
      rec_comb_order <= rec_q[`CRPT_BIT_COMB];
      rec_fir_skip <= rec_q[`CRPT_BIT_FIR];
      rec_shuffle_rate_double <= rec_q[`CRPT_BIT_SHUF];
      rec_lowpower_filter <= rec_q[`CRPT_BIT_LPF];
      play_modclk_half <= play_q[`CRPT_BIT_MODCLK];
      play_shuffle_rate_double <= play_q[`CRPT_BIT_SHUF];
      play_lowpower_filter <= play_q[`CRPT_BIT_LPF];
      play_current_ref_scale <= play_q[`CRPT_BIT_IREF];
      // reserved codes are stored as written but flagged; the analog side defines them
      bias_code_reserved <= (ref_q[`CRPT_LSB_BIAS +: 2] == `CRPT_BIAS_RESERVED);
      fullscale_code_reserved <= (ref_q[`CRPT_LSB_FS +: 2] == `CRPT_FS_RESERVED);
    end
  end

  // a write reaches the field output two edges later
  property p_ref_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && sel_ref) |-> ##2 (bias_regulator_gain == $past(reg_wdata[4], 2)
      && reference_fullscale_select == $past(reg_wdata[1:0], 2));
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("ref field not updated");

  property p_bias_sel;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && sel_ref) |-> ##2 (bias_output_select == $past(reg_wdata[3:2], 2));
  endproperty
  a_bias_sel: assert property (p_bias_sel) else $error("bias select wrong");

  property p_fs_rsvd;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && sel_ref && reg_wdata[1:0] == 2'h3) |-> ##2 fullscale_code_reserved;
  endproperty
  a_fs_rsvd: assert property (p_fs_rsvd) else $error("reserved fullscale not flagged");

  property p_rec_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && sel_rec) |-> ##2 (rec_modclk_half == $past(reg_wdata[7], 2)
      && rec_comb_order == $past(reg_wdata[6], 2));
  endproperty
  a_rec_write: assert property (p_rec_write) else $error("rec clock or comb wrong");

  property p_rec_fir;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && sel_rec) |-> ##2 (rec_fir_skip == $past(reg_wdata[5], 2)
      && rec_shuffle_rate_double == $past(reg_wdata[4], 2)
      && rec_lowpower_filter == $past(reg_wdata[2], 2));
  endproperty
  a_rec_fir: assert property (p_rec_fir) else $error("rec fir shuffle lpf wrong");

  property p_play_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && sel_play) |-> ##2 (play_modclk_half == $past(reg_wdata[7], 2)
      && play_shuffle_rate_double == $past(reg_wdata[4], 2)
      && play_lowpower_filter == $past(reg_wdata[2], 2)
      && play_current_ref_scale == $past(reg_wdata[1], 2));
  endproperty
  a_play_write: assert property (p_play_write) else $error("play field wrong");

  property p_readback;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && sel_play) ##1 (reg_rd && sel_play && !reg_wr)
      |=> (reg_rdata == ($past(reg_wdata, 2) & `CRPT_MASK_PLAY));
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  // reserved bits read zero whatever the host wrote into them
  property p_rsvd_zero;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && sel_ref) |=> ((reg_rdata & ~`CRPT_MASK_REF) == 8'h00);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

  property p_rsvd_rec;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && sel_rec) |=> ((reg_rdata & ~`CRPT_MASK_REC) == 8'h00);
  endproperty
  a_rsvd_rec: assert property (p_rsvd_rec) else $error("record reserved bits not zero");

  property p_rsvd_play;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && sel_play) |=> ((reg_rdata & ~`CRPT_MASK_PLAY) == 8'h00);
  endproperty
  a_rsvd_play: assert property (p_rsvd_play) else $error("playback reserved bits not zero");

  property p_reset_zero;
    @(posedge sys_clk) $rose(rst_n) |-> (reg_rdata == 8'h00 && !rec_modclk_half
      && !play_modclk_half && reference_fullscale_select == 2'h0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("not zero after reset");

  // every other field output clear on the edge after reset release
  property p_reset_fields;
    @(posedge sys_clk) $rose(rst_n) |-> (!bias_regulator_gain && !rec_comb_order
      && bias_output_select == crpt_pkg::CRPT_BIAS_VREF && !rec_fir_skip
      && !rec_shuffle_rate_double && !rec_lowpower_filter && !play_shuffle_rate_double
      && !play_lowpower_filter && !play_current_ref_scale && !bias_code_reserved
      && !fullscale_code_reserved);
  endproperty
  a_reset_fields: assert property (p_reset_fields) else $error("fields not clear");

  // reserved-code flags follow the stored codes both ways
  property p_code_flags;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && sel_ref) |-> ##2
      (bias_code_reserved == ($past(reg_wdata[3:2], 2) == `CRPT_BIAS_RESERVED)
      && fullscale_code_reserved == ($past(reg_wdata[1:0], 2) == `CRPT_FS_RESERVED));
  endproperty
  a_code_flags: assert property (p_code_flags) else $error("reserved code flag wrong");

  // unmapped reads return zero rather than a stale byte
  property p_rd_unmapped;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && sel_none) |=> (reg_rdata == 8'h00);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  // read data stands until the next read
  property p_rdata_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  // fields move only two edges after a write to a mapped register
  property p_fields_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    !(reg_wr && !sel_none) |-> ##2 $stable({bias_regulator_gain, bias_output_select,
      reference_fullscale_select, rec_modclk_half, rec_comb_order, rec_fir_skip,
      rec_shuffle_rate_double, rec_lowpower_filter, play_modclk_half,
      play_shuffle_rate_double, play_lowpower_filter, play_current_ref_scale,
      bias_code_reserved, fullscale_code_reserved});
  endproperty
  a_fields_hold: assert property (p_fields_hold) else $error("field moved without write");

  // a reference write leaves the power-tune outputs alone
  property p_ref_only;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && sel_ref) |-> ##2 $stable({rec_modclk_half, rec_comb_order, rec_fir_skip,
      rec_shuffle_rate_double, rec_lowpower_filter, play_modclk_half, play_shuffle_rate_double,
      play_lowpower_filter, play_current_ref_scale});
  endproperty
  a_ref_only: assert property (p_ref_only) else $error("ref write moved other fields");
endmodule
`default_nettype wire

// file: design/crpt_consts.svh
// constants for the reference, bias and power-tune register bank
`ifndef CRPT_CONSTS_SVH
`define CRPT_CONSTS_SVH
`define CRPT_ADDR_REF 8'h4d
`define CRPT_ADDR_REC 8'h4e
`define CRPT_ADDR_PLAY 8'h4f
`define CRPT_RESET_VAL 8'h00
`define CRPT_MASK_REF 8'h1f
`define CRPT_MASK_REC 8'hf4
`define CRPT_MASK_PLAY 8'h96
`define CRPT_BIT_GAIN 4
`define CRPT_LSB_BIAS 2
`define CRPT_LSB_FS 0
`define CRPT_BIT_MODCLK 7
`define CRPT_BIT_COMB 6
`define CRPT_BIT_FIR 5
`define CRPT_BIT_SHUF 4
`define CRPT_BIT_LPF 2
`define CRPT_BIT_IREF 1
`define CRPT_BIAS_RESERVED 2'h2
`define CRPT_FS_RESERVED 2'h3
`endif

// file: design/crpt_pkg.sv
// types for the reference, bias and power-tune register bank
package crpt_pkg;
  typedef logic [7:0] crpt_byte_t;
  typedef enum logic [1:0] {CRPT_BIAS_VREF, CRPT_BIAS_HALF, CRPT_BIAS_RSVD,
                            CRPT_BIAS_AVDD} crpt_bias_t;
endpackage

// file: design/crpt_reg8.sv
// one 8-bit configuration register with a writable-bit mask
`timescale 1ns/10ps
`default_nettype none
`include "crpt_consts.svh"
module crpt_reg8 #(
  parameter logic [7:0] WMASK = 8'hff
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // write side
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // stored value
  output logic [7:0] value_q
);
  logic [7:0] value_d;
  // reserved bits never store, so they always read zero
  assign value_d = wr_en ? (wr_data & WMASK) : value_q;
  // reset clears every bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= `CRPT_RESET_VAL;
    end else begin
      value_q <= value_d;
    end
  end
endmodule
`default_nettype wire

// file: test/crpt_regs_tb.sv
// self-checking bench for the reference, bias and power-tune register bank
`timescale 1ns/10ps
`default_nettype none
module crpt_regs_tb;
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rb;} crpt_row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic gain, rmh, rco, rfs, rsd, rlp, pmh, psd, plp, pcr, bres, fres;
  crpt_pkg::crpt_bias_t bsel;
  logic [1:0] fsel;
  logic [7:0] sh [1:3];
  int fails = 0;
  int tests_run = 0;
  wire logic [15:0] fields = {gain, bsel, fsel, rmh, rco, rfs, rsd, rlp, pmh, psd, plp, pcr,
                              bres, fres};
  // readback value is what the register keeps; reserved bits already cleared
  // half-reference bias rows keep fullscale at code 0 or 1, as the supply allows
  crpt_row_t rows [16] = '{
    '{8'h4d, 8'hff, 8'h1f}, '{8'h4e, 8'hff, 8'hf4}, '{8'h4f, 8'hff, 8'h96},
    '{8'h4d, 8'h00, 8'h00}, '{8'h4d, 8'h0a, 8'h0a}, '{8'h4d, 8'h15, 8'h15},
    '{8'h4d, 8'h0c, 8'h0c}, '{8'h4d, 8'he5, 8'h05}, '{8'h4e, 8'h0b, 8'h00},
    '{8'h4e, 8'h40, 8'h40}, '{8'h4e, 8'ha4, 8'ha4}, '{8'h4e, 8'h30, 8'h30},
    '{8'h4f, 8'h69, 8'h00}, '{8'h4f, 8'h82, 8'h82}, '{8'h4f, 8'h14, 8'h14},
    '{8'h4f, 8'h80, 8'h80}};
  crpt_regs u_crpt_regs (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .bias_regulator_gain(gain), .bias_output_select(bsel), .reference_fullscale_select(fsel),
    .rec_modclk_half(rmh), .rec_comb_order(rco), .rec_fir_skip(rfs),
    .rec_shuffle_rate_double(rsd), .rec_lowpower_filter(rlp), .play_modclk_half(pmh),
    .play_shuffle_rate_double(psd), .play_lowpower_filter(plp), .play_current_ref_scale(pcr),
    .bias_code_reserved(bres), .fullscale_code_reserved(fres));
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  // field outputs expected from the three stored bytes
  function automatic logic [15:0] exp_f(input logic [7:0] r, c, p);
    exp_f = {r[4], r[3:2], r[1:0], c[7], c[6], c[5], c[4], c[2], p[7], p[4], p[2], p[1],
             r[3:2] == 2'h2, r[1:0] == 2'h3};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle strobe, held until the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // data shows one cycle after the read edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1 chk(16'(reg_rdata), 16'(exp));
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    sh[1] = 8'h00;
    sh[2] = 8'h00;
    sh[3] = 8'h00;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 chk(fields, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      sh[rows[i].addr[1:0]] = rows[i].rb;
      rd(rows[i].addr, rows[i].rb);
      chk(fields, exp_f(sh[1], sh[2], sh[3]));
    end
    // neighbouring and unmapped addresses must not disturb the bank
    wr(8'h4c, 8'hff);
    wr(8'h50, 8'hff);
    rd(8'h50, 8'h00);
    chk(fields, exp_f(sh[1], sh[2], sh[3]));
    // write and read in the same cycle returns the old byte
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b1;
    reg_addr <= 8'h4f;
    reg_wdata <= 8'h00;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1 chk(16'(reg_rdata), 16'(sh[3]));
    rd(8'h4f, 8'h00);
    // read on the edge right after a write returns the new byte
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= 8'h4f;
    reg_wdata <= 8'h96;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1 chk(16'(reg_rdata), 16'h0096);
    // second reset in mid-run after loading every register
    wr(8'h4d, 8'h1f);
    wr(8'h4e, 8'hf4);
    repeat (2) @(posedge sys_clk);
    #1 chk(fields, exp_f(8'h1f, 8'hf4, 8'h96));
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    #1 chk(fields, 16'h0000);
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int a = 8'h4d; a <= 8'h4f; a++) rd(8'(a), 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
